// ### design/tsm_defines.vh
`ifndef TSM_DEFINES_VH
`define TSM_DEFINES_VH

// Register byte offsets on the APB slave.
`define TSM_OFF_SYNC 5'h00
`define TSM_OFF_MODE 5'h04
`define TSM_OFF_IRQ_STAT 5'h08
`define TSM_OFF_IRQ_MASK 5'h0C

// Reset values, and the bits that always read as one.
`define TSM_SYNC_RESET 8'hE0
`define TSM_MODE_RESET 8'h80
`define TSM_SYNC_FIXED 8'hE0
`define TSM_MODE_FIXED 8'h80

// Field positions in the mode register.
`define TSM_MODE_QUAD_BIT 6
`define TSM_MODE_OVERFLOW_FLAG_CONDITION_BIT 5

// Combination-mode field: upper bit set selects a paired PWM mode.
`define TSM_COMBO_PAIRED_BIT 1

// Interrupt status bit positions.
`define TSM_IRQ_OVF_BIT 0
`define TSM_IRQ_SYNC_BIT 1
`define TSM_IRQ_WIDTH 2

`endif

// ### design/tsm_top.v
// Behaviour
// - Clear sync bit: channel presets/clears alone
// - Set sync bit: joins group preset/clear
// - Sync register resets E0, top bits one
// - Mode register resets 80, bit7 one
// - Mode bit 6 selects channel-2 phase counting
// - Phase mode counts both edges, both pins
// - Other pin level sets count direction
// - Phase mode ignores edge and prescaler select
// - Clear, compare, capture, interrupts stay normal
// - Bit 5 picks overflow-only or both
// - Mode bits 4..0 select per-channel PWM
// - PWM pin high on A, low on B
// - Paired combo mode overrides PWM for 3,4
`timescale 1ns/100ps
`include "tsm_defines.vh"

module tsm_top #(
    parameter NUM_CH = 5
) (
    input wire MCLK_I,
    input wire RST_I,
    input wire STANDBY_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [31:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire PREADY_O,
    output reg [31:0] PRDATA_O,
    output wire PSLVERR_O,
    output wire IRQ_O,
    input wire [NUM_CH-1:0] CH_PRESET_REQ_I,
    input wire [NUM_CH-1:0] CH_CLEAR_REQ_I,
    output wire [NUM_CH-1:0] CH_PRESET_O,
    output wire [NUM_CH-1:0] CH_CLEAR_O,
    input wire EXT_CLOCK_IN_A_I,
    input wire EXT_CLOCK_IN_B_I,
    input wire CH2_NORMAL_TICK_I,
    output wire CH2_COUNT_EN_O,
    output wire CH2_COUNT_UP_O,
    output wire CH2_QUAD_MODE_O,
    input wire CH2_OVERFLOW_I,
    input wire CH2_UNDERFLOW_I,
    output wire CH2_OVF_SET_O,
    input wire [1:0] COMBO_MODE_I,
    input wire [NUM_CH-1:0] CMP_MATCH_A_I,
    input wire [NUM_CH-1:0] CMP_MATCH_B_I,
    output reg [NUM_CH-1:0] PWM_O,
    output wire [NUM_CH-1:0] PWM_OE_O
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    reg [4:0] sync_q;
    reg [6:0] mode_q;
    reg [`TSM_IRQ_WIDTH-1:0] irq_stat_q;
    reg [`TSM_IRQ_WIDTH-1:0] irq_mask_q;
    wire [`TSM_IRQ_WIDTH-1:0] irq_event;
    wire wr_en;
    wire rd_phase;
    wire [4:0] reg_addr;
    wire addr_hit;
    // Full-width copies of the reset values, so that only the implemented bits are loaded.
    localparam [7:0] sync_reset_val = `TSM_SYNC_RESET;
    localparam [7:0] mode_reset_val = `TSM_MODE_RESET;

    assign reg_addr = PADDR_I[4:0];
    assign addr_hit = (PADDR_I[31:5] == 27'h0000000) &&
                      ((reg_addr == `TSM_OFF_SYNC) || (reg_addr == `TSM_OFF_MODE) ||
                       (reg_addr == `TSM_OFF_IRQ_STAT) || (reg_addr == `TSM_OFF_IRQ_MASK));
    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && addr_hit;
    assign rd_phase = PSEL_I && !PENABLE_I && !PWRITE_I;

    // Every access completes in its first access cycle.
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;

    // Standby restores the same values as reset, but synchronously, so that
    // no port is ever loaded into a flip-flop under the asynchronous reset.
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            sync_q <= sync_reset_val[4:0];
            mode_q <= mode_reset_val[6:0];
        end else if (STANDBY_I) begin
            sync_q <= sync_reset_val[4:0];
            mode_q <= mode_reset_val[6:0];
        end else if (wr_en) begin
            if (reg_addr == `TSM_OFF_SYNC) begin
                sync_q <= PWDATA_I[4:0];
            end
            if (reg_addr == `TSM_OFF_MODE) begin
                mode_q <= PWDATA_I[6:0];
            end
        end
    end

    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_mask_q <= {`TSM_IRQ_WIDTH{1'b0}};
        end else if (STANDBY_I) begin
            irq_mask_q <= {`TSM_IRQ_WIDTH{1'b0}};
        end else if (wr_en && (reg_addr == `TSM_OFF_IRQ_MASK)) begin
            irq_mask_q <= PWDATA_I[`TSM_IRQ_WIDTH-1:0];
        end
    end

    // A new event in the cycle of a write-one-to-clear keeps its bit set.
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_stat_q <= {`TSM_IRQ_WIDTH{1'b0}};
        end else if (STANDBY_I) begin
            irq_stat_q <= {`TSM_IRQ_WIDTH{1'b0}};
        end else if (wr_en && (reg_addr == `TSM_OFF_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~PWDATA_I[`TSM_IRQ_WIDTH-1:0]) | irq_event;
        end else begin
            irq_stat_q <= irq_stat_q | irq_event;
        end
    end

    assign IRQ_O = |(irq_stat_q & irq_mask_q);

    // Read data is registered in the setup cycle and stands in the access cycle.
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            PRDATA_O <= 32'h00000000;
        end else if (rd_phase && !addr_hit) begin
            PRDATA_O <= 32'h00000000;
        end else if (rd_phase) begin
            case (reg_addr)
                `TSM_OFF_SYNC: PRDATA_O <= {24'h000000, `TSM_SYNC_FIXED | {3'b000, sync_q}};
                `TSM_OFF_MODE: PRDATA_O <= {24'h000000, `TSM_MODE_FIXED | {1'b0, mode_q}};
                `TSM_OFF_IRQ_STAT: PRDATA_O <= {{(32-`TSM_IRQ_WIDTH){1'b0}}, irq_stat_q};
                `TSM_OFF_IRQ_MASK: PRDATA_O <= {{(32-`TSM_IRQ_WIDTH){1'b0}}, irq_mask_q};
                default: PRDATA_O <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Synchronous preset and clear
    // ------------------------------------------------------------------
    // Combinational on purpose: the whole group must act in the cycle of the
    // request, so no register may sit between a member and the others.
    wire [NUM_CH-1:0] sync_mask;
    wire group_preset;
    wire group_clear;

    assign sync_mask = sync_q[NUM_CH-1:0];
    assign group_preset = |(CH_PRESET_REQ_I & sync_mask);
    assign group_clear = |(CH_CLEAR_REQ_I & sync_mask);
    assign CH_PRESET_O = CH_PRESET_REQ_I | (sync_mask & {NUM_CH{group_preset}});
    assign CH_CLEAR_O = CH_CLEAR_REQ_I | (sync_mask & {NUM_CH{group_clear}});

    // ------------------------------------------------------------------
    // Channel 2 phase counting
    // ------------------------------------------------------------------
    reg pin_a_q;
    reg pin_b_q;
    reg pin_a_prev_q;
    reg pin_b_prev_q;
    wire quad_mode;
    wire a_rise;
    wire a_fall;
    wire b_rise;
    wire b_fall;
    wire quad_edge;
    wire quad_down;

    // The pins are taken as synchronous; two register stages per pin give a clean edge detect.
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
            pin_a_prev_q <= 1'b0;
            pin_b_prev_q <= 1'b0;
        end else begin
            pin_a_q <= EXT_CLOCK_IN_A_I;
            pin_b_q <= EXT_CLOCK_IN_B_I;
            pin_a_prev_q <= pin_a_q;
            pin_b_prev_q <= pin_b_q;
        end
    end

    assign quad_mode = mode_q[`TSM_MODE_QUAD_BIT];
    assign a_rise = pin_a_q && !pin_a_prev_q;
    assign a_fall = !pin_a_q && pin_a_prev_q;
    assign b_rise = pin_b_q && !pin_b_prev_q;
    assign b_fall = !pin_b_q && pin_b_prev_q;
    assign quad_edge = a_rise || a_fall || b_rise || b_fall;
    // Down when the other pin's level matches these four cases; up otherwise.
    assign quad_down = (a_rise && !pin_b_q) || (b_rise && pin_a_q) ||
                       (a_fall && pin_b_q) || (b_fall && !pin_a_q);

    // Phase mode replaces the normal tick entirely, so the edge and prescaler
    // settings behind CH2_NORMAL_TICK_I have no effect there.
    assign CH2_COUNT_EN_O = quad_mode ? quad_edge : CH2_NORMAL_TICK_I;
    assign CH2_COUNT_UP_O = quad_mode ? !quad_down : 1'b1;
    assign CH2_QUAD_MODE_O = quad_mode;
    // Clearing, compare, capture and interrupt paths of channel 2 are not
    // routed through here, so they behave the same in either mode.

    // ------------------------------------------------------------------
    // Channel 2 overflow flag condition
    // ------------------------------------------------------------------
    assign CH2_OVF_SET_O = CH2_OVERFLOW_I ||
                           (CH2_UNDERFLOW_I && !mode_q[`TSM_MODE_OVERFLOW_FLAG_CONDITION_BIT]);

    assign irq_event[`TSM_IRQ_OVF_BIT] = CH2_OVF_SET_O;
    assign irq_event[`TSM_IRQ_SYNC_BIT] = group_preset || group_clear;

    // ------------------------------------------------------------------
    // PWM outputs
    // ------------------------------------------------------------------
    wire paired_mode;
    wire [NUM_CH-1:0] pwm_active;
    integer i;
    genvar ch;

    assign paired_mode = COMBO_MODE_I[`TSM_COMBO_PAIRED_BIT];

    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_pwm
            if (ch >= 3) begin : g_paired
                assign pwm_active[ch] = mode_q[ch] && !paired_mode;
            end else begin : g_plain
                assign pwm_active[ch] = mode_q[ch];
            end
        end
    endgenerate

    // When both matches hit in one cycle, the low level wins so the
    // pulse never stretches past its programmed end.
    always @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            PWM_O <= {NUM_CH{1'b0}};
        end else begin
            for (i = 0; i < NUM_CH; i = i + 1) begin
                if (!pwm_active[i]) begin
                    PWM_O[i] <= 1'b0;
                end else if (CMP_MATCH_B_I[i]) begin
                    PWM_O[i] <= 1'b0;
                end else if (CMP_MATCH_A_I[i]) begin
                    PWM_O[i] <= 1'b1;
                end
            end
        end
    end

    assign PWM_OE_O = pwm_active;

endmodule // tsm_top

// ### sim/tsm_properties.sv
`timescale 1ns/100ps
module tsm_properties #(
    parameter NUM_CH = 5
) (
    input wire MCLK_I,
    input wire RST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire [31:0] PADDR_I,
    input wire PSLVERR_O,
    input wire [NUM_CH-1:0] CH_PRESET_REQ_I,
    input wire [NUM_CH-1:0] CH_PRESET_O,
    input wire CH2_OVERFLOW_I,
    input wire CH2_OVF_SET_O,
    input wire [1:0] COMBO_MODE_I,
    input wire [NUM_CH-1:0] CMP_MATCH_A_I,
    input wire [NUM_CH-1:0] CMP_MATCH_B_I,
    input wire [NUM_CH-1:0] PWM_O,
    input wire [NUM_CH-1:0] PWM_OE_O,
    input wire EXT_CLOCK_IN_A_I,
    input wire EXT_CLOCK_IN_B_I,
    input wire CH2_QUAD_MODE_O,
    input wire CH2_COUNT_EN_O,
    input wire CH2_COUNT_UP_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    // Edges whose direction is fixed by the level of the other pin.
    sequence s_a_rise_low_b;
        CH2_QUAD_MODE_O && $rose(EXT_CLOCK_IN_A_I) && !EXT_CLOCK_IN_B_I;
    endsequence
    sequence s_b_rise_low_a;
        CH2_QUAD_MODE_O && $rose(EXT_CLOCK_IN_B_I) && !EXT_CLOCK_IN_A_I;
    endsequence
    a_unmapped_err: assert property (PSEL_I && PENABLE_I &&
        (PADDR_I[31:5] != 0 || PADDR_I[4:0] > 5'h0C || PADDR_I[1:0] != 2'h0) |-> PSLVERR_O)
        else $error("unmapped access not refused");
    a_preset_own: assert property ((CH_PRESET_O & CH_PRESET_REQ_I) == CH_PRESET_REQ_I)
        else $error("own preset lost");
    a_ovf_always: assert property (CH2_OVERFLOW_I |-> CH2_OVF_SET_O)
        else $error("overflow did not set flag");
    a_combo_override: assert property (COMBO_MODE_I[1] |-> PWM_OE_O[4:3] == 2'h0)
        else $error("paired mode did not override pulse mode");
    a_pwm_set: assert property (PWM_OE_O[0] && CMP_MATCH_A_I[0] && !CMP_MATCH_B_I[0] |=> PWM_O[0])
        else $error("pulse output not set");
    a_pwm_clear: assert property (PWM_OE_O[0] && CMP_MATCH_B_I[0] |=> !PWM_O[0])
        else $error("pulse output not cleared");
    a_quad_down: assert property (s_a_rise_low_b |=> CH2_COUNT_EN_O && !CH2_COUNT_UP_O)
        else $error("down count missing");
    a_quad_up: assert property (s_b_rise_low_a |=> CH2_COUNT_EN_O && CH2_COUNT_UP_O)
        else $error("up count missing");
endmodule // tsm_properties
bind tsm_top tsm_properties #(.NUM_CH(NUM_CH)) u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PSLVERR_O(PSLVERR_O), .CH_PRESET_REQ_I(CH_PRESET_REQ_I),
    .CH_PRESET_O(CH_PRESET_O), .CH2_OVERFLOW_I(CH2_OVERFLOW_I), .CH2_OVF_SET_O(CH2_OVF_SET_O),
    .COMBO_MODE_I(COMBO_MODE_I), .CMP_MATCH_A_I(CMP_MATCH_A_I), .CMP_MATCH_B_I(CMP_MATCH_B_I),
    .PWM_O(PWM_O), .PWM_OE_O(PWM_OE_O), .EXT_CLOCK_IN_A_I(EXT_CLOCK_IN_A_I),
    .EXT_CLOCK_IN_B_I(EXT_CLOCK_IN_B_I), .CH2_QUAD_MODE_O(CH2_QUAD_MODE_O),
    .CH2_COUNT_EN_O(CH2_COUNT_EN_O), .CH2_COUNT_UP_O(CH2_COUNT_UP_O));

// ### sim/tsm_encoder.sv
`timescale 1ns/100ps
module tsm_encoder (
    input wire clk_i,
    input wire rst_i,
    input wire step_i,
    input wire dir_i,
    output wire pin_a_o,
    output wire pin_b_o
);
    reg [1:0] pos_q;
    // Gray order: only one pin moves per step, as on a real encoder.
    assign pin_a_o = pos_q[1];
    assign pin_b_o = pos_q[1] ^ pos_q[0];
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            pos_q <= 2'h0;
        else if (step_i)
            pos_q <= dir_i ? pos_q + 2'h1 : pos_q - 2'h1;
    end
endmodule // tsm_encoder

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
    reg MCLK_I = 1'b0, RST_I = 1'b1, STANDBY_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    reg CH2_NORMAL_TICK_I = 1'b0, CH2_OVERFLOW_I = 1'b0, CH2_UNDERFLOW_I = 1'b0, step = 1'b0, dir = 1'b0, err;
    reg [31:0] PADDR_I = 32'h0, PWDATA_I = 32'h0, rd;
    reg [4:0] CH_PRESET_REQ_I = 5'h0, CH_CLEAR_REQ_I = 5'h0, CMP_MATCH_A_I = 5'h0, CMP_MATCH_B_I = 5'h0;
    reg [1:0] COMBO_MODE_I = 2'h0;
    reg [10:0] snap;
    wire [31:0] PRDATA_O;
    wire [4:0] CH_PRESET_O, CH_CLEAR_O, PWM_O, PWM_OE_O;
    wire PREADY_O, PSLVERR_O, IRQ_O, CH2_COUNT_EN_O, CH2_COUNT_UP_O, CH2_QUAD_MODE_O, CH2_OVF_SET_O;
    wire EXT_CLOCK_IN_A_I, EXT_CLOCK_IN_B_I;
    integer miscompares = 0, cmp_count = 0, ups = 0, downs = 0;
    always #10 MCLK_I = ~MCLK_I;
    tsm_top u_dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .STANDBY_I(STANDBY_I), .PSEL_I(PSEL_I),
        .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
        .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O),
        .CH_PRESET_REQ_I(CH_PRESET_REQ_I), .CH_CLEAR_REQ_I(CH_CLEAR_REQ_I),
        .CH_PRESET_O(CH_PRESET_O), .CH_CLEAR_O(CH_CLEAR_O), .EXT_CLOCK_IN_A_I(EXT_CLOCK_IN_A_I),
        .EXT_CLOCK_IN_B_I(EXT_CLOCK_IN_B_I), .CH2_NORMAL_TICK_I(CH2_NORMAL_TICK_I),
        .CH2_COUNT_EN_O(CH2_COUNT_EN_O), .CH2_COUNT_UP_O(CH2_COUNT_UP_O),
        .CH2_QUAD_MODE_O(CH2_QUAD_MODE_O), .CH2_OVERFLOW_I(CH2_OVERFLOW_I),
        .CH2_UNDERFLOW_I(CH2_UNDERFLOW_I), .CH2_OVF_SET_O(CH2_OVF_SET_O), .COMBO_MODE_I(COMBO_MODE_I),
        .CMP_MATCH_A_I(CMP_MATCH_A_I), .CMP_MATCH_B_I(CMP_MATCH_B_I), .PWM_O(PWM_O),
        .PWM_OE_O(PWM_OE_O));
    tsm_encoder u_enc (.clk_i(MCLK_I), .rst_i(RST_I), .step_i(step), .dir_i(dir),
        .pin_a_o(EXT_CLOCK_IN_A_I), .pin_b_o(EXT_CLOCK_IN_B_I));
    always @(posedge MCLK_I) if (CH2_COUNT_EN_O === 1'b1) begin
        if (CH2_COUNT_UP_O === 1'b1) ups <= ups + 1;
        else downs <= downs + 1;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [31:0] a, input [31:0] d);
        begin
            @(posedge MCLK_I);
            {PSEL_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'b1, w, a, d};
            @(posedge MCLK_I);
            PENABLE_I <= 1'b1;
            @(posedge MCLK_I);
            while (PREADY_O !== 1'b1) @(posedge MCLK_I);
            rd = PRDATA_O;
            err = PSLVERR_O;
            {PSEL_I, PENABLE_I} <= 2'h0;
            // Registers written at this edge are settled by the falling edge.
            @(negedge MCLK_I);
        end
    endtask
    // One-cycle event pulses; v is {overflow, underflow, preset, clear, match A, match B}.
    task pulse(input [21:0] v);
        begin
            @(posedge MCLK_I);
            {CH2_OVERFLOW_I, CH2_UNDERFLOW_I, CH_PRESET_REQ_I, CH_CLEAR_REQ_I, CMP_MATCH_A_I, CMP_MATCH_B_I} <= v;
            @(negedge MCLK_I);
            snap = {CH2_OVF_SET_O, CH_PRESET_O, CH_CLEAR_O};
            @(posedge MCLK_I);
            {CH2_OVERFLOW_I, CH2_UNDERFLOW_I, CH_PRESET_REQ_I, CH_CLEAR_REQ_I, CMP_MATCH_A_I, CMP_MATCH_B_I} <= 22'h0;
            @(negedge MCLK_I);
        end
    endtask
    task steps(input d);
        begin
            @(posedge MCLK_I);
            dir <= d;
            repeat (4) begin
                @(posedge MCLK_I);
                step <= 1'b1;
                @(posedge MCLK_I);
                step <= 1'b0;
                repeat (3) @(posedge MCLK_I);
            end
        end
    endtask
    task end_sim;
        begin
            if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        miscompares = miscompares + 1;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge MCLK_I);
        RST_I <= 1'b0;
        apb(1'b0, 32'h00, 32'h00); chk(rd, 32'hE0);
        apb(1'b0, 32'h04, 32'h00); chk(rd, 32'h80);
        apb(1'b0, 32'h10, 32'h00); chk({rd[30:0], err}, 32'h01);
        apb(1'b1, 32'h00, 32'h01); apb(1'b0, 32'h00, 32'h00); chk(rd, 32'hE1);
        apb(1'b1, 32'h04, 32'h7F); apb(1'b0, 32'h04, 32'h00); chk(rd, 32'hFF);
        apb(1'b1, 32'h04, 32'h00); apb(1'b1, 32'h00, 32'h06);
        pulse(22'h010000); chk(snap, 32'h0C0);
        pulse(22'h000400); chk(snap, 32'h001);
        pulse(22'h004000); chk(snap, 32'h010);
        pulse(22'h022000); chk(snap, 32'h0C8);
        apb(1'b1, 32'h0C, 32'h02); chk(IRQ_O, 1'b1);
        apb(1'b0, 32'h08, 32'h00); chk(rd, 32'h02);
        apb(1'b1, 32'h08, 32'h02); chk(IRQ_O, 1'b0);
        pulse(22'h100000); chk(snap[10], 1'b1);
        apb(1'b1, 32'h04, 32'h20);
        pulse(22'h100000); chk(snap[10], 1'b0);
        pulse(22'h200000); chk(snap[10], 1'b1);
        apb(1'b1, 32'h04, 32'h40); chk(CH2_QUAD_MODE_O, 1'b1);
        @(posedge MCLK_I) CH2_NORMAL_TICK_I <= 1'b1;
        steps(1'b1); chk({ups[7:0], downs[7:0]}, 32'h0400);
        steps(1'b0); chk({ups[7:0], downs[7:0]}, 32'h0404);
        apb(1'b1, 32'h04, 32'h1F); chk(PWM_OE_O, 5'h1F);
        chk({CH2_COUNT_EN_O, CH2_COUNT_UP_O}, 32'h3);
        @(posedge MCLK_I) CH2_NORMAL_TICK_I <= 1'b0;
        @(posedge MCLK_I) COMBO_MODE_I <= 2'h2;
        pulse(22'h0003E0); chk({PWM_OE_O, PWM_O}, 32'h0E7);
        @(posedge MCLK_I) COMBO_MODE_I <= 2'h0;
        pulse(22'h0003E0); chk(PWM_O, 5'h1F);
        pulse(22'h0003FF); chk(PWM_O, 5'h00);
        @(posedge MCLK_I) STANDBY_I <= 1'b1;
        apb(1'b0, 32'h04, 32'h00); chk(rd, 32'h80);
        @(posedge MCLK_I) STANDBY_I <= 1'b0;
        apb(1'b0, 32'h00, 32'h00); chk(rd, 32'hE0);
        apb(1'b0, 32'h04, 32'h00); chk(rd, 32'h80);
        end_sim;
    end
endmodule // tb
